// [jtsp_pkg.sv]
/*
 * Constants, codes and lookup functions for the transport sample packer.
 * Assumes the user supplies one frame of samples per channel at once.
 */
package jtsp_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int NLANE    = 8;
   localparam int NCHAN    = 4;
   localparam int NSAMP    = 10;
   localparam int SAMP_W   = 9;
   localparam int LANE_W   = 64;
   localparam int C12_W    = 12;
   localparam int C10_W    = 10;
   localparam int B8_W     = 8;
   localparam int PACK_LAT = 1;

   // -----------------------------------------------------------------
   // Link format codes and part kinds
   // -----------------------------------------------------------------
   localparam logic [3:0] FMT_0 = 4'h0;
   localparam logic [3:0] FMT_1 = 4'h1;
   localparam logic [3:0] FMT_2 = 4'h2;
   localparam logic [3:0] FMT_3 = 4'h3;
   localparam logic [3:0] FMT_4 = 4'h4;
   localparam logic [3:0] FMT_5 = 4'h5;

   localparam logic [1:0] PART_QUAD   = 2'h0;
   localparam logic [1:0] PART_DUAL   = 2'h1;
   localparam logic [1:0] PART_SINGLE = 2'h2;

   // -----------------------------------------------------------------
   // Padding and reset values
   // -----------------------------------------------------------------
   localparam logic [2:0]  PAD3     = 3'h0;
   localparam logic        PAD1     = 1'h0;
   localparam logic [3:0]  TAIL     = 4'h0;
   localparam logic [3:0]  OCT_RST  = 4'h0;
   localparam logic [7:0]  LEN_RST  = 8'h00;

   // -----------------------------------------------------------------
   // Lookups
   // -----------------------------------------------------------------
   function automatic logic [2:0] chan_count(input logic [1:0] p);
      case (p)
         PART_QUAD: chan_count = 3'h4;
         PART_DUAL: chan_count = 3'h2;
         default:   chan_count = 3'h1;
      endcase
   endfunction

   function automatic logic [3:0] lane_count(input logic [3:0] m,
                                             input logic [1:0] p);
      logic [2:0] n;
      n = chan_count(p);
      case (m)
         FMT_0:   lane_count = {n, 1'b0};
         FMT_1:   lane_count = (n == 3'h4) ? 4'h6 :
                               (n == 3'h2) ? 4'h3 : 4'h2;
         FMT_2,
         FMT_3:   lane_count = {1'b0, n};
         FMT_4:   lane_count = (n == 3'h4) ? 4'h3 : {1'b0, n};
         FMT_5:   lane_count = (n == 3'h4) ? 4'h2 : 4'h1;
         default: lane_count = 4'h0;
      endcase
   endfunction

   function automatic logic [3:0] octet_count(input logic [3:0] m);
      case (m)
         FMT_0:   octet_count = 4'h8;
         FMT_2:   octet_count = 4'h1;
         FMT_3:   octet_count = 4'h5;
         FMT_1,
         FMT_4,
         FMT_5:   octet_count = 4'h2;
         default: octet_count = OCT_RST;
      endcase
   endfunction

   function automatic logic [C12_W-1:0] cont12(input logic [SAMP_W-1:0] s);
      cont12 = {s, PAD3};
   endfunction

endpackage

// [jtsp_chan_pack.sv]
/*
 * Per-channel container builder: forms every layout one channel needs.
 * Assumes absent channels are already forced to zero by the caller.
 */
`timescale 1ns/10ps
`default_nettype none

module jtsp_chan_pack
   import jtsp_pkg::*;
(
   input  wire logic [NSAMP-1:0][SAMP_W-1:0] samp,
   output logic      [LANE_W-1:0]            even_w,
   output logic      [LANE_W-1:0]            odd_w,
   output logic      [4*C10_W-1:0]           w10,
   output logic      [2*C12_W-1:0]           pair12,
   output logic      [C12_W-1:0]             c12,
   output logic      [B8_W-1:0]              b8
);

   // -----------------------------------------------------------------
   // Layouts
   // -----------------------------------------------------------------
   always_comb begin
      even_w = '0;
      odd_w  = '0;
      w10    = '0;
      for (int i = 0; i < 5; i++) begin
         even_w[LANE_W-1-C12_W*i -: C12_W] = cont12(samp[2*i]);
         odd_w[LANE_W-1-C12_W*i -: C12_W]  = cont12(samp[2*i+1]);
      end
      even_w[3:0] = TAIL;
      odd_w[3:0]  = TAIL;
      for (int i = 0; i < 4; i++) begin
         w10[4*C10_W-1-C10_W*i -: C10_W] = {samp[i], PAD1};
      end
      pair12 = {cont12(samp[0]), cont12(samp[1])};
      c12    = cont12(samp[0]);
      b8     = samp[0][SAMP_W-1 -: B8_W];
   end

endmodule

`default_nettype wire

// [jtsp_packer.sv]
/*
 * Transport-layer sample packer: maps one frame of A..D samples to lanes.
 * Assumes link encoding, scrambling and sync follow downstream.
 */
// Overview of operation
// - Format 0 lane 3 carries B odd samples, 12-bit containers, tail.
// - Format 0 quad lanes 6 and 7 carry D even and odd samples.
// - Format 1 packs 9-bit samples, 6/3/2 lanes, two octets each.
// - Format 1 quad lanes 4 and 5 carry C1 tail and D0, D1.
// - Format 2 sends one 8-bit sample per lane, channels in order.
// - Format 3 gives each channel one lane of four 10-bit containers.
// - Format 4 streams 12-bit containers over 3/2/1 lanes, 64b/66b.
// - Format 4 quad lane 2 carries C0 low bit then D0 container.
// - Format 5 streams 8-bit samples over 2/1/1 lanes, 64b/66b.
// - All tail bits are zero.
// - Samples MSB first; extra container bits are zero.
// - Lowest lanes used; higher lanes off and zero.
`timescale 1ns/10ps
`default_nettype none

module jtsp_packer
   import jtsp_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         srst,
   input  wire logic                         frame_valid,
   input  wire logic [3:0]                   link_format_select,
   input  wire logic [1:0]                   part_kind,
   input  wire logic [NSAMP-1:0][SAMP_W-1:0] ch_a,
   input  wire logic [NSAMP-1:0][SAMP_W-1:0] ch_b,
   input  wire logic [NSAMP-1:0][SAMP_W-1:0] ch_c,
   input  wire logic [NSAMP-1:0][SAMP_W-1:0] ch_d,
   output logic      [NLANE-1:0][LANE_W-1:0] lane_data,
   output logic                              lane_valid,
   output logic      [NLANE-1:0]             lane_enable,
   output logic      [3:0]                   lane_octets,
   output logic                              use_64b66b,
   output logic                              format_error
);

   // -----------------------------------------------------------------
   // Channel masking and containers
   // -----------------------------------------------------------------
   logic [2:0]                              nch;
   logic [3:0]                              lanes_now;
   logic [NCHAN-1:0][NSAMP-1:0][SAMP_W-1:0] samp;
   logic [NCHAN-1:0][LANE_W-1:0]            even_w;
   logic [NCHAN-1:0][LANE_W-1:0]            odd_w;
   logic [NCHAN-1:0][4*C10_W-1:0]           w10;
   logic [NCHAN-1:0][2*C12_W-1:0]           pr;
   logic [NCHAN-1:0][C12_W-1:0]             c12;
   logic [NCHAN-1:0][B8_W-1:0]              b8;

   assign nch       = chan_count(part_kind);
   assign lanes_now = lane_count(link_format_select, part_kind);

   always_comb begin
      samp[0] = ch_a;
      samp[1] = (nch >= 3'h2) ? ch_b : '0;
      samp[2] = (nch == 3'h4) ? ch_c : '0;
      samp[3] = (nch == 3'h4) ? ch_d : '0;
   end

   for (genvar g = 0; g < NCHAN; g++) begin : g_pack
      jtsp_chan_pack u_pack (
         .samp   (samp[g]),
         .even_w (even_w[g]),
         .odd_w  (odd_w[g]),
         .w10    (w10[g]),
         .pair12 (pr[g]),
         .c12    (c12[g]),
         .b8     (b8[g])
      );
   end

   // -----------------------------------------------------------------
   // Lane mapping
   // -----------------------------------------------------------------
   logic [NLANE-1:0][LANE_W-1:0] lane_next;
   logic [47:0]                  s_ab;
   logic [47:0]                  s_cd;
   logic [47:0]                  s_c4;
   logic [31:0]                  s_b5;

   always_comb begin
      lane_next = '0;
      s_ab      = {pr[0], pr[1]};
      s_cd      = {pr[2], pr[3]};
      s_c4      = {c12[0], c12[1], c12[2], c12[3]};
      s_b5      = {b8[0], b8[1], b8[2], b8[3]};
      case (link_format_select)
         FMT_0: begin
            for (int c = 0; c < NCHAN; c++) begin
               lane_next[2*c]   = even_w[c];
               lane_next[2*c+1] = odd_w[c];
            end
         end
         FMT_1: begin
            for (int i = 0; i < 3; i++) begin
               lane_next[i][63:48]   = s_ab[47-16*i -: 16];
               lane_next[i+3][63:48] = s_cd[47-16*i -: 16];
            end
         end
         FMT_2: begin
            for (int c = 0; c < NCHAN; c++) begin
               lane_next[c][63:56] = b8[c];
            end
         end
         FMT_3: begin
            for (int c = 0; c < NCHAN; c++) begin
               lane_next[c][63:24] = w10[c];
            end
         end
         FMT_4: begin
            for (int i = 0; i < 3; i++) begin
               lane_next[i][63:48] = s_c4[47-16*i -: 16];
            end
         end
         FMT_5: begin
            for (int i = 0; i < 2; i++) begin
               lane_next[i][63:48] = s_b5[31-16*i -: 16];
            end
         end
         default: begin
            lane_next = '0;
         end
      endcase
      for (int i = 0; i < NLANE; i++) begin
         if (i >= int'(lanes_now)) begin
            lane_next[i] = '0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------
   logic [NLANE-1:0][LANE_W-1:0] lane_data_reg;
   logic                         lane_valid_reg;
   logic [NLANE-1:0]             lane_enable_reg;
   logic [NLANE-1:0]             lane_enable_next;
   logic [3:0]                   lane_octets_reg;
   logic                         use_64b66b_reg;
   logic                         format_error_reg;

   always_comb begin
      for (int i = 0; i < NLANE; i++) begin
         lane_enable_next[i] = (i < int'(lanes_now));
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lane_data_reg <= '0;
      end else if (frame_valid) begin
         lane_data_reg <= lane_next;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lane_valid_reg <= 1'b0;
      end else begin
         lane_valid_reg <= frame_valid;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lane_enable_reg  <= LEN_RST;
         lane_octets_reg  <= OCT_RST;
         use_64b66b_reg   <= 1'b0;
         format_error_reg <= 1'b0;
      end else begin
         lane_enable_reg  <= lane_enable_next;
         lane_octets_reg  <= octet_count(link_format_select);
         use_64b66b_reg   <= (link_format_select == FMT_4) ||
                             (link_format_select == FMT_5);
         format_error_reg <= (link_format_select > FMT_5);
      end
   end

   assign lane_data    = lane_data_reg;
   assign lane_valid   = lane_valid_reg;
   assign lane_enable  = lane_enable_reg;
   assign lane_octets  = lane_octets_reg;
   assign use_64b66b   = use_64b66b_reg;
   assign format_error = format_error_reg;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_fmt0_lane3;
      frame_valid && link_format_select == FMT_0 && part_kind < PART_SINGLE |=>
         lane_data[3][63:52] == {$past(ch_b[1]), PAD3} &&
         lane_data[3][15:4] == {$past(ch_b[9]), PAD3};
   endproperty
   a_fmt0_lane3: assert property (p_fmt0_lane3)
      else $error("format 0 lane 3 mismatch");

   property p_fmt0_lanes67;
      frame_valid && link_format_select == FMT_0 &&
      part_kind == PART_QUAD |=>
         lane_data[6][63:52] == {$past(ch_d[0]), PAD3} &&
         lane_data[7][15:4] == {$past(ch_d[9]), PAD3};
   endproperty
   a_fmt0_lanes67: assert property (p_fmt0_lanes67)
      else $error("format 0 lanes 6/7 mismatch");

   property p_fmt1_lane0;
      frame_valid && link_format_select == FMT_1 |=>
         lane_data[0][63:48] == {$past(ch_a[0]), PAD3, $past(ch_a[1][8:5])}
         && lane_data[2][47:0] == '0;
   endproperty
   a_fmt1_lane0: assert property (p_fmt1_lane0)
      else $error("format 1 lane 0 mismatch");

   property p_fmt1_lane45;
      frame_valid && link_format_select == FMT_1 &&
      part_kind == PART_QUAD |=>
         lane_data[4][63:48] == {$past(ch_c[1][4:0]), PAD3,
                                 $past(ch_d[0][8:1])} &&
         lane_data[5][63:48] == {$past(ch_d[0][0]), PAD3,
                                 $past(ch_d[1]), PAD3};
   endproperty
   a_fmt1_lane45: assert property (p_fmt1_lane45)
      else $error("format 1 lanes 4/5 mismatch");

   property p_fmt2;
      frame_valid && link_format_select == FMT_2 &&
      part_kind < PART_SINGLE |=>
         lane_data[1] == {$past(ch_b[0][8:1]), 56'h0};
   endproperty
   a_fmt2: assert property (p_fmt2)
      else $error("format 2 lane 1 mismatch");

   property p_fmt3;
      frame_valid && link_format_select == FMT_3 |=>
         lane_data[0][63:24] == {$past(ch_a[0]), PAD1, $past(ch_a[1]), PAD1,
                                 $past(ch_a[2]), PAD1, $past(ch_a[3]), PAD1};
   endproperty
   a_fmt3: assert property (p_fmt3)
      else $error("format 3 lane 0 mismatch");

   property p_fmt4_single;
      frame_valid && link_format_select == FMT_4 &&
      part_kind == PART_SINGLE |=>
         lane_data[0][63:48] == {$past(ch_a[0]), PAD3, TAIL} &&
         lane_enable == 8'h01 && use_64b66b;
   endproperty
   a_fmt4_single: assert property (p_fmt4_single)
      else $error("format 4 single lane 0 mismatch");

   property p_fmt4_lane2;
      frame_valid && link_format_select == FMT_4 &&
      part_kind == PART_QUAD |=>
         lane_data[2][63:48] == {$past(ch_c[0][0]), PAD3,
                                 $past(ch_d[0]), PAD3};
   endproperty
   a_fmt4_lane2: assert property (p_fmt4_lane2)
      else $error("format 4 lane 2 mismatch");

   property p_fmt5;
      frame_valid && link_format_select == FMT_5 &&
      part_kind == PART_SINGLE |=>
         lane_data[0][63:48] == {$past(ch_a[0][8:1]), 8'h00};
   endproperty
   a_fmt5: assert property (p_fmt5)
      else $error("format 5 single lane 0 mismatch");

   property p_tail;
      lane_valid && $past(link_format_select) == FMT_0 |->
         lane_data[0][3:0] == TAIL && lane_data[7][3:0] == TAIL;
   endproperty
   a_tail: assert property (p_tail)
      else $error("tail bits not zero");

   property p_pad;
      lane_valid && $past(link_format_select) == FMT_3 |->
         lane_data[0][24] == PAD1 && lane_data[0][23:0] == '0;
   endproperty
   a_pad: assert property (p_pad)
      else $error("padding bits not zero");

   property p_unused;
      ##1 (lane_valid && !lane_enable[7]) |-> lane_data[7] == '0;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused lane carries data");

   c_fmt0_quad: cover property (frame_valid && link_format_select == FMT_0
                                && part_kind == PART_QUAD ##1 lane_valid);
   c_fmt1_single: cover property (frame_valid && link_format_select == FMT_1
                                  && part_kind == PART_SINGLE ##1 lane_valid);
   c_fmt5_quad: cover property (frame_valid && link_format_select == FMT_5
                                && part_kind == PART_QUAD ##1 lane_valid);

endmodule

`default_nettype wire

// [jtsp_rx_model.sv]
/*
 * Receiver model: unpacks sample 0 of each channel from the lanes.
 * Assumes it is told the same link format and part kind as the packer.
 */
`timescale 1ns/10ps
`default_nettype none

module jtsp_rx_model
   import jtsp_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         srst,
   input  wire logic [NLANE-1:0][LANE_W-1:0] lane_data,
   input  wire logic                         lane_valid,
   input  wire logic [3:0]                   link_format_select,
   input  wire logic [1:0]                   part_kind,
   output logic      [3:0][SAMP_W-1:0]       rx_s0,
   output logic                              rx_valid
);
   logic [95:0]            st;
   logic [3:0][SAMP_W-1:0] un;

   // ---------------------------------------------------------------
   // Unpack, dropping pad, tail and filler bits
   // ---------------------------------------------------------------
   always_comb begin
      st = '0;
      un = '0;
      for (int i = 0; i < 6; i++) begin
         st[95-16*i -: 16] = lane_data[i][63:48];
      end
      for (int c = 0; c < 4; c++) begin
         case (link_format_select)
            FMT_0: un[c] = lane_data[2*c][63:55];
            FMT_1: un[c] = st[95-24*c -: 9];
            FMT_2: un[c] = {lane_data[c][63:56], 1'b0};
            FMT_3: un[c] = lane_data[c][63:55];
            FMT_4: un[c] = st[95-12*c -: 9];
            FMT_5: un[c] = {st[95-8*c -: 8], 1'b0};
            default: un[c] = '0;
         endcase
      end
      // Only the lowest lanes are wired; absent channels read zero
      if (part_kind != PART_QUAD) begin
         un[2] = '0;
         un[3] = '0;
      end
      if (part_kind > PART_DUAL) begin
         un[1] = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_valid <= 1'b0;
         rx_s0    <= '0;
      end else begin
         rx_valid <= lane_valid;
         if (lane_valid) begin
            rx_s0 <= un;
         end
      end
   end
endmodule
`default_nettype wire

// [jtsp_packer_bench.sv]
/*
 * Self-checking testbench for the transport sample packer.
 * Assumes the receiver model file is compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none

module jtsp_packer_bench
   import jtsp_pkg::*;
;
   logic                         clk;
   logic                         srst;
   logic                         frame_valid;
   logic [3:0]                   link_format_select;
   logic [1:0]                   part_kind;
   logic [NSAMP-1:0][SAMP_W-1:0] sa, sb, sc, sd;
   logic [NLANE-1:0][LANE_W-1:0] lane_data;
   logic                         lane_valid;
   logic [NLANE-1:0]             lane_enable;
   logic [3:0]                   lane_octets;
   logic                         use_64b66b;
   logic                         format_error;
   logic [3:0][SAMP_W-1:0]       rx_s0;
   logic                         rx_valid;
   logic [3:0][NSAMP-1:0][SAMP_W-1:0] ce;
   int                           n_errors = 0;
   int                           compares = 0;

   jtsp_packer u_dut (.clk(clk), .srst(srst), .frame_valid(frame_valid),
      .link_format_select(link_format_select), .part_kind(part_kind),
      .ch_a(sa), .ch_b(sb), .ch_c(sc), .ch_d(sd), .lane_data(lane_data),
      .lane_valid(lane_valid), .lane_enable(lane_enable),
      .lane_octets(lane_octets), .use_64b66b(use_64b66b),
      .format_error(format_error));

   jtsp_rx_model u_rx (.clk(clk), .srst(srst), .lane_data(lane_data),
      .lane_valid(lane_valid), .link_format_select(link_format_select),
      .part_kind(part_kind), .rx_s0(rx_s0), .rx_valid(rx_valid));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic summarize;
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic set_pat(input logic [8:0] base);
      for (int n = 0; n < NSAMP; n++) begin
         sa[n] = base + 9'(n * 37);
         sb[n] = ~sa[n];
         sc[n] = sa[n] ^ 9'h0f0;
         sd[n] = {sa[n][3:0], sa[n][8:4]};
      end
   endtask

   // Octets in [15:12], lane counts quad/dual/single below
   function automatic logic [15:0] tab(input logic [3:0] f);
      case (f)
         FMT_0:   tab = 16'h8842;
         FMT_1:   tab = 16'h2632;
         FMT_2:   tab = 16'h1421;
         FMT_3:   tab = 16'h5421;
         FMT_4:   tab = 16'h2321;
         FMT_5:   tab = 16'h2211;
         default: tab = 16'h0000;
      endcase
   endfunction

   task automatic exp_lanes(input logic [3:0] f, input logic [1:0] p,
                            output logic [NLANE-1:0][LANE_W-1:0] el);
      logic [95:0] st;
      st = '0;
      el = '0;
      ce[0] = sa;
      ce[1] = (p < PART_SINGLE) ? sb : '0;
      ce[2] = (p == PART_QUAD) ? sc : '0;
      ce[3] = (p == PART_QUAD) ? sd : '0;
      for (int j = 0; j < 8; j++) begin
         case (f)
            FMT_0: for (int k = 0; k < 5; k++)
               el[j][63-12*k -: 12] = {ce[j/2][2*k+j%2], 3'h0};
            FMT_1: st[95-12*j -: 12] = {ce[j/4*2+(j%4)/2][j%2], 3'h0};
            FMT_2: if (j < 4) el[j][63:56] = ce[j][0][8:1];
            FMT_3: if (j < 4) for (int k = 0; k < 4; k++)
               el[j][63-10*k -: 10] = {ce[j][k], 1'b0};
            FMT_4: if (j < 4) st[95-12*j -: 12] = {ce[j][0], 3'h0};
            FMT_5: if (j < 4) st[95-8*j -: 8] = ce[j][0][8:1];
            default: st = '0;
         endcase
      end
      if (f == FMT_1 || f == FMT_4 || f == FMT_5) begin
         for (int i = 0; i < 6; i++) el[i][63:48] = st[95-16*i -: 16];
      end
   endtask

   task automatic send_frame(input logic [3:0] f, input logic [1:0] p,
                             input bit chk_rx);
      logic [NLANE-1:0][LANE_W-1:0] el;
      logic [15:0]                  t;
      int                           pi;
      link_format_select = f;
      part_kind = p;
      frame_valid = 1'b1;
      exp_lanes(f, p, el);
      t = tab(f);
      pi = (p > PART_SINGLE) ? 2 : int'(p);
      @(negedge clk);
      frame_valid = 1'b0;
      if (f <= FMT_5) check(lane_valid, 1'b1);
      for (int i = 0; i < NLANE; i++) begin
         check(lane_data[i], el[i]);
      end
      check(lane_enable, (64'h1 << t[11-4*pi -: 4]) - 64'h1);
      check(lane_octets, t[15:12]);
      check(use_64b66b, f == FMT_4 || f == FMT_5);
      check(format_error, f > FMT_5);
      @(negedge clk);
      check(lane_valid, 1'b0);
      if (chk_rx) begin
         check(rx_valid, 1'b1);
         for (int j = 0; j < 4; j++) begin
            check(rx_s0[j], (f == FMT_2 || f == FMT_5) ?
                  {ce[j][0][8:1], 1'b0} : ce[j][0]);
         end
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_all_formats;
      for (int b = 0; b < 2; b++) begin
         for (int f = 0; f < 6; f++) begin
            for (int p = 0; p < 4; p++) begin
               set_pat(b ? 9'h1c3 : 9'h05a);
               send_frame(4'(f), 2'(p), 1'b1);
            end
         end
      end
   endtask

   task automatic t_ones;
      {sa, sb, sc, sd} = '1;
      send_frame(FMT_0, PART_QUAD, 1'b0);
      check(lane_data[3], 64'hff8f_f8ff_8ff8_ff80);
      check(lane_data[6], 64'hff8f_f8ff_8ff8_ff80);
      send_frame(FMT_1, PART_QUAD, 1'b0);
      check(lane_data[0], 64'hff8f_0000_0000_0000);
      check(lane_data[4], 64'hf8ff_0000_0000_0000);
      check(lane_data[5], 64'h8ff8_0000_0000_0000);
      send_frame(FMT_2, PART_DUAL, 1'b0);
      check(lane_data[1], 64'hff00_0000_0000_0000);
      check(lane_data[2], 64'h0000_0000_0000_0000);
      send_frame(FMT_3, PART_QUAD, 1'b0);
      check(lane_data[0], 64'hffbf_effb_fe00_0000);
      send_frame(FMT_4, PART_SINGLE, 1'b0);
      check(lane_data[0], 64'hff80_0000_0000_0000);
      send_frame(FMT_4, PART_QUAD, 1'b0);
      check(lane_data[2], 64'h8ff8_0000_0000_0000);
      send_frame(FMT_5, PART_SINGLE, 1'b0);
      check(lane_data[0], 64'hff00_0000_0000_0000);
   endtask

   task automatic t_back_to_back;
      logic [NLANE-1:0][LANE_W-1:0] e;
      link_format_select = FMT_3;
      part_kind = PART_QUAD;
      set_pat(9'h011);
      exp_lanes(FMT_3, PART_QUAD, e);
      frame_valid = 1'b1;
      for (int r = 0; r < 2; r++) begin
         @(negedge clk);
         set_pat(9'h122);
         frame_valid = (r == 0);
         check(lane_valid, 1'b1);
         for (int i = 0; i < NLANE; i++) check(lane_data[i], e[i]);
         exp_lanes(FMT_3, PART_QUAD, e);
      end
      @(negedge clk);
   endtask

   task automatic t_hold;
      logic [NLANE-1:0][LANE_W-1:0] e;
      set_pat(9'h033);
      send_frame(FMT_0, PART_DUAL, 1'b0);
      exp_lanes(FMT_0, PART_DUAL, e);
      set_pat(9'h0ff);
      repeat (3) @(negedge clk);
      for (int i = 0; i < NLANE; i++) check(lane_data[i], e[i]);
   endtask

   task automatic t_invalid_and_reset;
      for (int f = 6; f < 16; f++) send_frame(4'(f), PART_QUAD, 1'b0);
      send_frame(FMT_2, PART_QUAD, 1'b0);
      srst = 1'b1;
      @(negedge clk);
      srst = 1'b0;
      check(lane_data[0], 64'h0);
      check(lane_enable, 8'h00);
      check(lane_octets, OCT_RST);
      @(negedge clk);
      send_frame(FMT_2, PART_QUAD, 1'b1);
   endtask

   initial begin
      srst = 1'b1;
      frame_valid = 1'b0;
      link_format_select = FMT_0;
      part_kind = PART_QUAD;
      set_pat(9'h000);
      repeat (8) @(negedge clk);
      srst = 1'b0;
      t_all_formats;
      t_ones;
      t_back_to_back;
      t_hold;
      t_invalid_and_reset;
      summarize;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize;
   end
endmodule
`default_nettype wire
